// ==== logic/scs_status_regs.vh ====
// Constants for the SPI card status reporting block.
// Assumes a 32-bit plain register port with a 4-bit word address.
`ifndef SCS_STATUS_REGS_VH
`define SCS_STATUS_REGS_VH

// Register word addresses
`define SCS_ADDR_FLAGS     4'h0
`define SCS_ADDR_CTRL      4'h1
`define SCS_ADDR_OCR       4'h2
`define SCS_ADDR_LINK      4'h3
`define SCS_ADDR_CSD_BASE  4'h4
`define SCS_ADDR_CID_BASE  4'h8
`define SCS_ADDR_WORD_MSK  4'hC

// Control register fields
`define SCS_CTRL_RESET_CMD 0
`define SCS_CTRL_INIT_DONE 1
`define SCS_CTRL_RST_VAL   2'h0

// Link status register fields
`define SCS_LINK_BUSY      0
`define SCS_LINK_GAP_OK    1
`define SCS_LINK_SEL       2

// Token shapes
`define SCS_TOK_W          16
`define SCS_SHORT_BITS     5'h08
`define SCS_STATUS_BITS    5'h10
`define SCS_ERRTOK_BITS    5'h08
`define SCS_BITS_ZERO      5'h00
`define SCS_BITS_ONE       5'h01
`define SCS_FILL_BYTE      8'hFF
`define SCS_ERR_PAD        3'h0

`endif

// ==== logic/scs_status.v ====
// SPI card status flags, token serializer and register view.
// Assumes the SPI clock and chip select come from a host outside clk_i's domain,
// and that card events and token requests come from logic on clk_i.
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "scs_status_regs.vh"

// Behaviour
// [RULE_01] Flags leave in short response, two-byte status response and data error token.
// [RULE_02] Each error flag clears once sent to the host in any token; cleared at token load here, even if deselect abandons it.
// [RULE_03] Out-of-range sets on bad argument range; status and error token; clears on read.
// [RULE_04] Address error sets on misaligned address; short and status; clears on read.
// [RULE_05] Erase sequence error sets on bad erase ordering; clears on read.
// [RULE_06] Erase parameter error, status only, sets on bad erase parameters.
// [RULE_07] Parameter error sets on invalid command parameter; clears on read.
// [RULE_08] Write protect violation, status only, sets on program of protected block.
// [RULE_09] Command CRC error sets when previous command CRC failed; clears on read.
// [RULE_10] Illegal command sets when command not allowed in state; clears on read.
// [RULE_11] ECC failure sets on uncorrectable data; status and error token.
// [RULE_12] Controller error sets on internal fault; status and error token.
// [RULE_13] General error sets on unknown failure; status and error token.
// [RULE_14] Protected erase skip, status only, sets on partial erase.
// [RULE_15] Locked bit is live lock state, never cleared by reading.
// [RULE_16] Erase reset sets when pending erase is cancelled; clears on read.
// [RULE_17] Idle set at power-up or reset command, dropped after initialization.
// [RULE_18] Configuration overwrite, status only, sets on forbidden config change.
// [RULE_19] Only operating-conditions, card-data and identification registers are exposed.
// [RULE_20] Host keeps clocking at least the response gap after any token.
// [RULE_21] Error token low four bits match status second byte error meanings.
// [RULE_22] Data output floats while deselected, drives high between tokens.
// [RULE_23] Lock command failed, status only, sets on lock/unlock error.
module scs_status #(
  parameter [31:0]  OCR_VALUE     = 32'h00FF8000,
  parameter [127:0] CSD_VALUE     = 128'h0,
  parameter [127:0] CID_VALUE     = 128'h0, // Arbitrary identity content
  parameter         GAP_CYCLES    = 8,
  parameter         GAP_W         = 4
) (
  input  wire        clk_i,
  input  wire        rst_i,
  // SPI pins
  input  wire        spi_sck_i,
  input  wire        spi_cs_n_i,
  output wire        spi_miso_o,
  output wire        spi_miso_oe_n_o,
  // Card events, one-cycle pulses; card_locked_i is a level
  input  wire        ev_out_of_range_i,
  input  wire        ev_addr_err_i,
  input  wire        ev_erase_seq_i,
  input  wire        ev_erase_param_i,
  input  wire        ev_param_err_i,
  input  wire        ev_wp_violation_i,
  input  wire        ev_crc_err_i,
  input  wire        ev_illegal_cmd_i,
  input  wire        ev_ecc_fail_i,
  input  wire        ev_ctrl_err_i,
  input  wire        ev_gen_err_i,
  input  wire        ev_wp_erase_skip_i,
  input  wire        ev_erase_reset_i,
  input  wire        ev_cfg_overwrite_i,
  input  wire        ev_lock_fail_i,
  input  wire        ev_reset_cmd_i,
  input  wire        ev_init_done_i,
  input  wire        card_locked_i,
  // Token requests
  input  wire        short_req_i,
  input  wire        status_req_i,
  input  wire        errtok_req_i,
  output wire        tok_busy_o,
  output reg         tok_done_o,
  output wire        gap_ok_o,
  // Register port
  input  wire [3:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_we_i,
  input  wire        reg_re_i,
  output reg  [31:0] reg_rdata_o
);

  // Pin synchronisers
  reg  [2:0]  sck_sync_q;
  reg  [1:0]  cs_sync_q;
  wire        sck_fall;
  wire        sck_rise;
  wire        selected;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_sync_q <= 3'h0;
      cs_sync_q  <= 2'h3;
    end else begin
      sck_sync_q <= {sck_sync_q[1:0], spi_sck_i};
      cs_sync_q  <= {cs_sync_q[0], spi_cs_n_i};
    end
  end

  // Stage 0 only feeds stage 1; edges come from stages 1 and 2
  assign sck_rise = sck_sync_q[1] & ~sck_sync_q[2];
  assign sck_fall = ~sck_sync_q[1] & sck_sync_q[2];
  assign selected = ~cs_sync_q[1];

  // Sticky error flags
  reg  out_of_range_q, addr_err_q, erase_seq_q, erase_param_q;
  reg  param_err_q, wp_violation_q, crc_err_q, illegal_cmd_q;
  reg  ecc_fail_q, ctrl_err_q, gen_err_q, wp_erase_skip_q;
  reg  erase_reset_q, cfg_overwrite_q, lock_fail_q, idle_q;
  reg  [1:0] ctrl_q;

  wire [7:0]  short_byte;
  wire [7:0]  status_byte2;
  wire [7:0]  errtok_byte;
  wire        load_short;
  wire        load_status;
  wire        load_errtok;
  wire        clr_short;
  wire        clr_status2;
  wire        clr_errtok;

  assign short_byte   = {1'b0, param_err_q, addr_err_q, erase_seq_q,
                         crc_err_q, illegal_cmd_q, erase_reset_q, idle_q}; // see [RULE_01]
  assign status_byte2 = {out_of_range_q | cfg_overwrite_q, erase_param_q,
                         wp_violation_q, ecc_fail_q, ctrl_err_q, gen_err_q,
                         wp_erase_skip_q | lock_fail_q, card_locked_i}; // see [RULE_15]
  // Same bit meanings as status second byte bits 0, 2, 3, 4 and 7, in other positions
  assign errtok_byte  = {`SCS_ERR_PAD, card_locked_i, out_of_range_q,
                         ecc_fail_q, ctrl_err_q, gen_err_q}; // see [RULE_21]

  // Clear what the token just carried; the whole status clears both bytes
  assign clr_short   = load_short | load_status;                   // see [RULE_02]
  assign clr_status2 = load_status;                                // see [RULE_02]
  assign clr_errtok  = load_status | load_errtok;                  // see [RULE_02]

  // Set wins over a clear in the same cycle
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_of_range_q  <= 1'b0;
      addr_err_q      <= 1'b0;
      erase_seq_q     <= 1'b0;
      erase_param_q   <= 1'b0;
      param_err_q     <= 1'b0;
      wp_violation_q  <= 1'b0;
      crc_err_q       <= 1'b0;
      illegal_cmd_q   <= 1'b0;
      ecc_fail_q      <= 1'b0;
      ctrl_err_q      <= 1'b0;
      gen_err_q       <= 1'b0;
      wp_erase_skip_q <= 1'b0;
      erase_reset_q   <= 1'b0;
      cfg_overwrite_q <= 1'b0;
      lock_fail_q     <= 1'b0;
      idle_q          <= 1'b1;                                      // see [RULE_17]
    end else begin
      out_of_range_q  <= ev_out_of_range_i  | (out_of_range_q  & ~clr_errtok);  // see [RULE_03]
      addr_err_q      <= ev_addr_err_i      | (addr_err_q      & ~clr_short);   // see [RULE_04]
      erase_seq_q     <= ev_erase_seq_i     | (erase_seq_q     & ~clr_short);   // see [RULE_05]
      erase_param_q   <= ev_erase_param_i   | (erase_param_q   & ~clr_status2); // see [RULE_06]
      param_err_q     <= ev_param_err_i     | (param_err_q     & ~clr_short);   // see [RULE_07]
      wp_violation_q  <= ev_wp_violation_i  | (wp_violation_q  & ~clr_status2); // see [RULE_08]
      crc_err_q       <= ev_crc_err_i       | (crc_err_q       & ~clr_short);   // see [RULE_09]
      illegal_cmd_q   <= ev_illegal_cmd_i   | (illegal_cmd_q   & ~clr_short);   // see [RULE_10]
      ecc_fail_q      <= ev_ecc_fail_i      | (ecc_fail_q      & ~clr_errtok);  // see [RULE_11]
      ctrl_err_q      <= ev_ctrl_err_i      | (ctrl_err_q      & ~clr_errtok);  // see [RULE_12]
      gen_err_q       <= ev_gen_err_i       | (gen_err_q       & ~clr_errtok);  // see [RULE_13]
      wp_erase_skip_q <= ev_wp_erase_skip_i | (wp_erase_skip_q & ~clr_status2); // see [RULE_14]
      erase_reset_q   <= ev_erase_reset_i   | (erase_reset_q   & ~clr_short);   // see [RULE_16]
      cfg_overwrite_q <= ev_cfg_overwrite_i | (cfg_overwrite_q & ~clr_status2); // see [RULE_18]
      lock_fail_q     <= ev_lock_fail_i     | (lock_fail_q     & ~clr_status2); // see [RULE_23]
      // Reset command wins over a simultaneous init done
      if (ev_reset_cmd_i | ctrl_q[`SCS_CTRL_RESET_CMD])
        idle_q <= 1'b1;                                             // see [RULE_17]
      else if (ev_init_done_i | ctrl_q[`SCS_CTRL_INIT_DONE])
        idle_q <= 1'b0;                                             // see [RULE_17]
    end
  end

  // Token serializer
  localparam ST_IDLE  = 2'h0;
  localparam ST_SHIFT = 2'h1;
  localparam ST_GAP   = 2'h2;

  reg  [1:0]            state_q;
  reg  [`SCS_TOK_W-1:0] shift_q;
  reg  [4:0]            bits_q;
  reg                   miso_q;
  reg  [GAP_W-1:0]      gap_q;
  wire                  can_load;

  assign can_load    = (state_q != ST_SHIFT) & selected;
  // Status request outranks the error token, which outranks the short response
  assign load_status = can_load & status_req_i;
  assign load_errtok = can_load & ~status_req_i & errtok_req_i;
  assign load_short  = can_load & ~status_req_i & ~errtok_req_i & short_req_i;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q    <= ST_IDLE;
      shift_q    <= {`SCS_TOK_W{1'b1}};
      bits_q     <= `SCS_BITS_ZERO;
      miso_q     <= 1'b1;
      gap_q      <= {GAP_W{1'b0}};
      tok_done_o <= 1'b0;
    end else begin
      tok_done_o <= 1'b0;
      case (state_q)
        ST_IDLE, ST_GAP: begin
          if (state_q == ST_GAP && sck_rise && gap_q != GAP_CYCLES[GAP_W-1:0])
            gap_q <= gap_q + 1'b1;                                  // see [RULE_20]
          if (state_q == ST_GAP && !selected)
            state_q <= ST_IDLE;
          if (load_status) begin
            shift_q <= {short_byte[6:0], status_byte2, 1'b1};
            miso_q  <= short_byte[7];                               // see [RULE_01]
            bits_q  <= `SCS_STATUS_BITS;
            state_q <= ST_SHIFT;
          end else if (load_errtok) begin
            shift_q <= {errtok_byte[6:0], `SCS_FILL_BYTE, 1'b1};
            miso_q  <= errtok_byte[7];                              // see [RULE_01]
            bits_q  <= `SCS_ERRTOK_BITS;
            state_q <= ST_SHIFT;
          end else if (load_short) begin
            shift_q <= {short_byte[6:0], `SCS_FILL_BYTE, 1'b1};
            miso_q  <= short_byte[7];                               // see [RULE_01]
            bits_q  <= `SCS_SHORT_BITS;
            state_q <= ST_SHIFT;
          end else begin
            miso_q <= 1'b1;                                         // see [RULE_22]
          end
        end
        ST_SHIFT: begin
          if (!selected) begin
            // Deselect abandons the token; flags were already cleared
            state_q <= ST_IDLE;
            miso_q  <= 1'b1;
            bits_q  <= `SCS_BITS_ZERO;
          end else if (sck_fall) begin
            if (bits_q == `SCS_BITS_ONE) begin
              miso_q     <= 1'b1;                                   // see [RULE_22]
              bits_q     <= `SCS_BITS_ZERO;
              state_q    <= ST_GAP;
              gap_q      <= {GAP_W{1'b0}};
              tok_done_o <= 1'b1;
            end else begin
              miso_q  <= shift_q[`SCS_TOK_W-1];
              shift_q <= {shift_q[`SCS_TOK_W-2:0], 1'b1};
              bits_q  <= bits_q - 1'b1;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          miso_q  <= 1'b1;
        end
      endcase
    end
  end

  // Floats whenever the synchronised chip select is high
  assign spi_miso_o      = miso_q | ~selected;                      // see [RULE_22]
  assign spi_miso_oe_n_o = ~selected;                               // see [RULE_22]
  assign tok_busy_o      = (state_q == ST_SHIFT);
  // Host counts on this only if it keeps clocking past the token
  assign gap_ok_o        = (state_q == ST_GAP) &&
                           (gap_q == GAP_CYCLES[GAP_W-1:0]);        // see [RULE_20]

  // Register port
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      ctrl_q <= `SCS_CTRL_RST_VAL;
    else if (reg_we_i && reg_addr_i == `SCS_ADDR_CTRL)
      ctrl_q <= reg_wdata_i[1:0];
    else
      ctrl_q <= ctrl_q & ~(2'h1 << `SCS_CTRL_RESET_CMD); // Reset command self-clears
  end

  reg  [31:0] rdata_d;
  wire [1:0]  word_sel;

  assign word_sel = reg_addr_i[1:0];

  // Reads of flags here are a debug view: they do not clear anything
  always @* begin
    rdata_d = 32'h0;
    case (reg_addr_i & `SCS_ADDR_WORD_MSK)
      `SCS_ADDR_FLAGS: begin
        case (reg_addr_i)
          `SCS_ADDR_FLAGS: rdata_d = {8'h0, errtok_byte, short_byte, status_byte2};
          `SCS_ADDR_CTRL:  rdata_d = {30'h0, ctrl_q};
          `SCS_ADDR_OCR:   rdata_d = OCR_VALUE;                     // see [RULE_19]
          `SCS_ADDR_LINK:  rdata_d = {29'h0, selected, gap_ok_o, tok_busy_o};
          default:         rdata_d = 32'h0;
        endcase
      end
      `SCS_ADDR_CSD_BASE: rdata_d = CSD_VALUE[{word_sel, 5'h00} +: 32]; // see [RULE_19]
      `SCS_ADDR_CID_BASE: rdata_d = CID_VALUE[{word_sel, 5'h00} +: 32]; // see [RULE_19]
      default:            rdata_d = 32'h0;
    endcase
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      reg_rdata_o <= 32'h0;
    else if (reg_re_i)
      reg_rdata_o <= rdata_d;
    else
      reg_rdata_o <= 32'h0;
  end

endmodule // scs_status

// ==== tb/scs_status_monitor.sv ====
// Checker for the status block pins and register port.
// Assumes it is bound into scs_status and clocked on clk_i.
`timescale 1ns/10ps
`include "scs_status_regs.vh"
module scs_status_monitor #(
  parameter [31:0] OCR_VALUE = 32'h00FF8000
) (
  input wire        clk_i,
  input wire        rst_i,
  input wire        spi_cs_n_i,
  input wire        spi_miso_o,
  input wire        spi_miso_oe_n_o,
  input wire        ev_addr_err_i,
  input wire        ev_ecc_fail_i,
  input wire        ev_reset_cmd_i,
  input wire        card_locked_i,
  input wire        tok_busy_o,
  input wire        tok_done_o,
  input wire        gap_ok_o,
  input wire [3:0]  reg_addr_i,
  input wire        reg_re_i,
  input wire [31:0] reg_rdata_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire flags_rd = reg_re_i && (reg_addr_i == `SCS_ADDR_FLAGS);
  // Three samples cover the two-stage select synchronizer
  desel_float_a: assert property (spi_cs_n_i [*3] |-> spi_miso_oe_n_o)
    else $error("data output driven while deselected");
  idle_high_a: assert property (!spi_miso_oe_n_o && !tok_busy_o |-> spi_miso_o)
    else $error("data output not high between tokens");
  rdata_once_a: assert property (!$past(reg_re_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside its cycle");
  ocr_view_a: assert property (reg_re_i && reg_addr_i == `SCS_ADDR_OCR
    |=> reg_rdata_o == OCR_VALUE) else $error("operating conditions mismatch");
  unmapped_zero_a: assert property (reg_re_i && reg_addr_i >= `SCS_ADDR_WORD_MSK
    |=> reg_rdata_o == 32'h0) else $error("unmapped read not zero");
  addr_flag_a: assert property (ev_addr_err_i ##1 flags_rd |=> reg_rdata_o[13])
    else $error("address flag not set");
  ecc_both_a: assert property (ev_ecc_fail_i ##1 flags_rd
    |=> reg_rdata_o[18] && reg_rdata_o[4]) else $error("ecc flag missing");
  idle_cmd_a: assert property (ev_reset_cmd_i ##1 flags_rd |=> reg_rdata_o[8])
    else $error("idle not set by reset command");
  locked_live_a: assert property (flags_rd |=> reg_rdata_o[0] == $past(card_locked_i)
    && reg_rdata_o[20] == $past(card_locked_i)) else $error("locked bit not live");
  done_pulse_a: assert property (tok_done_o |-> spi_miso_o && !tok_busy_o ##1 !tok_done_o)
    else $error("token end malformed");
  cover property (tok_done_o);
  cover property (flags_rd ##1 reg_rdata_o[0]);
  cover property ($rose(gap_ok_o));
endmodule // scs_status_monitor

bind scs_status scs_status_monitor #(.OCR_VALUE(OCR_VALUE)) i_scs_status_monitor (
  .clk_i, .rst_i, .spi_cs_n_i, .spi_miso_o, .spi_miso_oe_n_o, .ev_addr_err_i,
  .ev_ecc_fail_i, .ev_reset_cmd_i, .card_locked_i, .tok_busy_o, .tok_done_o,
  .gap_ok_o, .reg_addr_i, .reg_re_i, .reg_rdata_o);

// ==== tb/scs_host_model.sv ====
// Behavioural SPI host: drives clock and select, captures card output.
// Assumes the bench decides when frames run; clock stands still otherwise.
`timescale 1ns/10ps
module scs_host_model #(
  parameter HALF_NS = 400
) (
  input  wire        sel_i,
  input  wire        run_i,
  input  wire        spi_miso_i,
  output reg         spi_sck_o,
  output wire        spi_cs_n_o,
  output reg  [15:0] rx_o
);
  initial spi_sck_o = 1'b0;
  initial rx_o = 16'h0;
  assign spi_cs_n_o = ~sel_i;
  // Mode 0: idle low, sample on the rise; keeps running through the gap
  always #HALF_NS spi_sck_o = run_i ? ~spi_sck_o : 1'b0;
  always @(posedge spi_sck_o) rx_o <= {rx_o[14:0], spi_miso_i};
endmodule // scs_host_model

// ==== tb/tb.sv ====
// Bench for the status block: register port tasks and host token frames.
// Assumes a pull-up on the data line while the card floats it.
`timescale 1ns/10ps
`include "scs_status_regs.vh"
`define CHK(n, e, s) begin checked = checked + 1; if ((s) !== (e)) begin num_errors = num_errors + 1; $display("ERROR %s exp %h got %h", n, e, s); end end
module tb;
  localparam [31:0]  OPERATING_CONDITIONS_REG = 32'h00FF8000;
  localparam [127:0] CARD_SPECIFIC_DATA_REG = 128'h0123456789ABCDEF0011223344556677;
  localparam [127:0] CARD_IDENTIFICATION_REG = 128'hFEDCBA98765432100F1E2D3C4B5A6978;
  localparam [479:0] EXP = {32'h2, 32'h80, 32'h200, 32'h2, 32'h10004, 32'h20008, 32'h40010,
    32'h400, 32'h800, 32'h20, 32'h4000, 32'h40, 32'h1000, 32'h2000, 32'h80080};
  reg         clk_i = 1'b0, rst_i = 1'b1, sel = 1'b0, run = 1'b0, lock = 1'b0;
  reg  [16:0] ev = 17'h0;
  reg  [2:0]  req = 3'h0;
  reg  [3:0]  addr = 4'h0;
  reg  [31:0] wdata = 32'h0;
  reg         we = 1'b0, re = 1'b0;
  wire        sck, cs_n, miso, oe_n, busy, done, gap_ok;
  wire [31:0] rdata;
  wire [15:0] rx;
  wire        line = oe_n ? 1'b1 : miso;
  integer     num_errors = 0, checked = 0, i;
  always #50 clk_i = ~clk_i;
  scs_host_model i_scs_host_model (.sel_i(sel), .run_i(run), .spi_miso_i(line),
    .spi_sck_o(sck), .spi_cs_n_o(cs_n), .rx_o(rx));
  scs_status #(.OCR_VALUE(OPERATING_CONDITIONS_REG), .CSD_VALUE(CARD_SPECIFIC_DATA_REG), .CID_VALUE(CARD_IDENTIFICATION_REG), .GAP_CYCLES(8)) i_scs_status (
    .clk_i(clk_i), .rst_i(rst_i), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
    .spi_miso_o(miso), .spi_miso_oe_n_o(oe_n),
    .ev_out_of_range_i(ev[0]), .ev_addr_err_i(ev[1]), .ev_erase_seq_i(ev[2]),
    .ev_erase_param_i(ev[3]), .ev_param_err_i(ev[4]), .ev_wp_violation_i(ev[5]),
    .ev_crc_err_i(ev[6]), .ev_illegal_cmd_i(ev[7]), .ev_ecc_fail_i(ev[8]),
    .ev_ctrl_err_i(ev[9]), .ev_gen_err_i(ev[10]), .ev_wp_erase_skip_i(ev[11]),
    .ev_erase_reset_i(ev[12]), .ev_cfg_overwrite_i(ev[13]), .ev_lock_fail_i(ev[14]),
    .ev_reset_cmd_i(ev[15]), .ev_init_done_i(ev[16]), .card_locked_i(lock),
    .short_req_i(req[2]), .status_req_i(req[1]), .errtok_req_i(req[0]),
    .tok_busy_o(busy), .tok_done_o(done), .gap_ok_o(gap_ok),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata));
  task final_report;
    begin
      if (num_errors == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // All tasks but final_report start and end just after a rising edge
  task wr(input [3:0] a, input [31:0] d);
    begin
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clk_i) we <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task rdc(input [3:0] a, input [31:0] e);
    begin
      addr <= a;
      re <= 1'b1;
      @(posedge clk_i) re <= 1'b0;
      @(negedge clk_i) `CHK("rdata", e, rdata)
      @(posedge clk_i);
    end
  endtask
  task pulse(input [16:0] v);
    begin
      ev <= v;
      @(posedge clk_i) ev <= 17'h0;
    end
  endtask
  task tok(input [2:0] r, input integer nb, input [15:0] e);
    integer k;
    begin
      sel <= 1'b1;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i) `CHK("idle_line", 2'b10, {miso, oe_n})
      @(posedge clk_i) req <= r;
      @(posedge clk_i) req <= 3'h0;
      repeat (2) @(posedge clk_i);
      run <= 1'b1;
      k = 0;
      while (done !== 1'b1 && k < 400) begin
        @(negedge clk_i);
        k = k + 1;
      end
      `CHK("token", e, rx & ~(16'hFFFF << nb))
      // Host keeps clocking the response gap before letting go
      repeat (8) @(posedge sck);
      repeat (4) @(negedge clk_i);
      `CHK("gap_ok", 1'b1, gap_ok)
      @(posedge clk_i) run <= 1'b0;
      sel <= 1'b0;
      repeat (4) @(negedge clk_i);
      `CHK("float", 1'b1, oe_n)
      @(posedge clk_i);
    end
  endtask
  initial begin
    #2000000;
    num_errors = num_errors + 1;
    final_report;
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(`SCS_ADDR_FLAGS, 32'h100);
    rdc(`SCS_ADDR_CTRL, 32'h0);
    wr(`SCS_ADDR_OCR, 32'hFFFFFFFF);
    rdc(`SCS_ADDR_OCR, OPERATING_CONDITIONS_REG);
    rdc(`SCS_ADDR_CSD_BASE + 4'h3, CARD_SPECIFIC_DATA_REG[127:96]);
    rdc(`SCS_ADDR_CID_BASE, CARD_IDENTIFICATION_REG[31:0]);
    rdc(4'hD, 32'h0);
    pulse(17'h10000);
    rdc(`SCS_ADDR_FLAGS, 32'h0);
    pulse(17'h08000);
    rdc(`SCS_ADDR_FLAGS, 32'h100);
    wr(`SCS_ADDR_CTRL, 32'h2);
    rdc(`SCS_ADDR_FLAGS, 32'h0);
    for (i = 0; i < 15; i = i + 1) begin
      pulse(17'h1 << i);
      rdc(`SCS_ADDR_FLAGS, EXP[32*i +: 32]);
      tok(3'b010, 16, EXP[32*i +: 16]);
      rdc(`SCS_ADDR_FLAGS, 32'h0);
    end
    pulse(17'h3);
    tok(3'b001, 8, 16'h08);
    rdc(`SCS_ADDR_FLAGS, 32'h2000);
    pulse(17'h440);
    tok(3'b100, 8, 16'h28);
    rdc(`SCS_ADDR_FLAGS, 32'h10004);
    tok(3'b111, 16, 16'h0004);
    lock <= 1'b1;
    @(posedge clk_i);
    rdc(`SCS_ADDR_FLAGS, 32'h100001);
    tok(3'b010, 16, 16'h0001);
    rdc(`SCS_ADDR_FLAGS, 32'h100001);
    lock <= 1'b0;
    pulse(17'h4);
    req <= 3'b010;
    @(posedge clk_i) req <= 3'h0;
    @(posedge clk_i);
    rdc(`SCS_ADDR_FLAGS, 32'h1000);
    tok(3'b010, 16, 16'h1000);
    final_report;
  end
endmodule // tb
